// [hdl/adc_conv_ctrl.sv]
// converter control: registers, prescaler, start/trigger logic, result lock
module adc_conv_ctrl (
    input  wire logic                                          clk,
    input  wire logic                                          nrst,
    input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]               avs_address,
    input  wire logic                                          avs_read,
    input  wire logic                                          avs_write,
    input  wire logic [adc_ctrl_pkg::DATA_W-1:0]               avs_writedata,
    output logic      [adc_ctrl_pkg::DATA_W-1:0]               avs_readdata,
    output logic                                               avs_waitrequest,
    input  wire logic [adc_ctrl_pkg::NUM_TRIG-1:1]             trig_src,
    input  wire logic [adc_ctrl_pkg::NUM_CH*adc_ctrl_pkg::RES_W-1:0] channel_sample,
    output logic      [adc_ctrl_pkg::CH_W-1:0]                 channel_select,
    output logic                                               converter_on,
    output logic                                               conv_done_event
);

    // prescaler tap mask: setting 0 and 1 both divide by two
    function automatic logic [adc_ctrl_pkg::PCNT_W-1:0] presc_mask(
        input logic [adc_ctrl_pkg::PRESC_W-1:0] p
    );
        logic [adc_ctrl_pkg::PCNT_W:0] one_hot;
        one_hot = '0;
        one_hot[(p == '0) ? 1 : p] = 1'b1;
        presc_mask = one_hot[adc_ctrl_pkg::PCNT_W-1:0] - 1'b1;
    endfunction

    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    logic                                  ack_q, ack_d;
    logic [adc_ctrl_pkg::DATA_W-1:0]       rdata_q, rdata_d;
    logic                                  enable_q, enable_d;
    logic                                  start_q, start_d;
    logic                                  auto_q, auto_d;
    logic                                  done_flag_q, done_flag_d;
    logic [adc_ctrl_pkg::PRESC_W-1:0]      presc_sel_q, presc_sel_d;
    logic [adc_ctrl_pkg::TS_W-1:0]         trig_sel_q, trig_sel_d;
    logic                                  left_q, left_d;
    logic [adc_ctrl_pkg::CH_W-1:0]         ch_reg_q, ch_reg_d;
    logic [adc_ctrl_pkg::CH_W-1:0]         ch_act_q, ch_act_d;
    logic [adc_ctrl_pkg::RES_W-1:0]        res_q, res_d;
    logic                                  lock_q, lock_d;
    logic                                  first_q, first_d;
    logic                                  trig_prev_q, trig_prev_d;
    logic [adc_ctrl_pkg::PCNT_W-1:0]       pcnt_q, pcnt_d;
    logic                                  event_q, event_d;

    logic                                  acc_wr;
    logic                                  acc_rd;
    logic                                  tick;
    logic                                  trig_level;
    logic                                  trig_edge;
    logic                                  launch;
    logic                                  core_busy;
    adc_ctrl_pkg::conv_result_t            core_res;
    logic [adc_ctrl_pkg::RES_W-1:0]        sample_sel;
    logic [7:0]                            res_lo;
    logic [7:0]                            res_hi;

    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign acc_wr          = avs_write && !avs_waitrequest;
    assign acc_rd          = avs_read && !avs_waitrequest;

    assign trig_level = (trig_sel_q == adc_ctrl_pkg::TRIG_FREERUN) ? 1'b0
                        : trig_src[trig_sel_q];
    assign trig_edge  = trig_level && !trig_prev_q;
    assign tick       = enable_q && ((pcnt_q & presc_mask(presc_sel_q))
                                     == presc_mask(presc_sel_q));
    // done and tick never share a cycle, the guard only documents intent
    assign launch     = start_q && !core_busy && !core_res.done && tick;
    assign sample_sel = channel_sample[ch_act_q*adc_ctrl_pkg::RES_W +: adc_ctrl_pkg::RES_W];

    always_comb begin
        res_lo = '0;
        res_hi = '0;
        if (left_q) begin
            res_lo = {res_q[1:0], 6'h00};
            res_hi = res_q[9:2];
        end else begin
            res_lo = res_q[7:0];
            res_hi = {6'h00, res_q[9:8]};
        end
    end

    always_comb begin
        ack_d       = (avs_read || avs_write) && !ack_q;
        rdata_d     = rdata_q;
        enable_d    = enable_q;
        start_d     = start_q;
        auto_d      = auto_q;
        done_flag_d = done_flag_q;
        presc_sel_d = presc_sel_q;
        trig_sel_d  = trig_sel_q;
        left_d      = left_q;
        ch_reg_d    = ch_reg_q;
        ch_act_d    = ch_act_q;
        res_d       = res_q;
        lock_d      = lock_q;
        first_d     = first_q;
        trig_prev_d = trig_level;
        pcnt_d      = pcnt_q + 1'b1;
        event_d     = 1'b0;

        if (avs_read && !ack_q) begin
            rdata_d = '0;
            case (avs_address)
                adc_ctrl_pkg::CTRL_A_OFF: begin
                    rdata_d[adc_ctrl_pkg::CA_ENABLE_BIT] = enable_q;
                    rdata_d[adc_ctrl_pkg::CA_START_BIT]  = start_q;
                    rdata_d[adc_ctrl_pkg::CA_AUTO_BIT]   = auto_q;
                    rdata_d[adc_ctrl_pkg::CA_DONE_BIT]   = done_flag_q;
                    rdata_d[adc_ctrl_pkg::CA_PRESC_LSB +: adc_ctrl_pkg::PRESC_W] = presc_sel_q;
                end
                adc_ctrl_pkg::CTRL_B_OFF: rdata_d[adc_ctrl_pkg::CB_TS_LSB +: adc_ctrl_pkg::TS_W] = trig_sel_q;
                adc_ctrl_pkg::INSEL_OFF: begin
                    rdata_d[adc_ctrl_pkg::IS_LEFT_BIT] = left_q;
                    rdata_d[adc_ctrl_pkg::IS_CH_LSB +: adc_ctrl_pkg::CH_W] = ch_reg_q;
                end
                adc_ctrl_pkg::RES_LO_OFF: rdata_d[7:0] = res_lo;
                adc_ctrl_pkg::RES_HI_OFF: rdata_d[7:0] = res_hi;
                default: rdata_d = '0;
            endcase
        end

        if (acc_wr) begin
            case (avs_address)
                adc_ctrl_pkg::CTRL_A_OFF: begin
                    enable_d    = avs_writedata[adc_ctrl_pkg::CA_ENABLE_BIT];
                    auto_d      = avs_writedata[adc_ctrl_pkg::CA_AUTO_BIT];
                    presc_sel_d = avs_writedata[adc_ctrl_pkg::CA_PRESC_LSB +: adc_ctrl_pkg::PRESC_W];
                    if (avs_writedata[adc_ctrl_pkg::CA_START_BIT]) begin
                        start_d = 1'b1;
                    end
                    if (avs_writedata[adc_ctrl_pkg::CA_DONE_BIT]) begin
                        done_flag_d = 1'b0;
                    end
                end
                adc_ctrl_pkg::CTRL_B_OFF: trig_sel_d = avs_writedata[adc_ctrl_pkg::CB_TS_LSB +: adc_ctrl_pkg::TS_W];
                adc_ctrl_pkg::INSEL_OFF: begin
                    left_d   = avs_writedata[adc_ctrl_pkg::IS_LEFT_BIT];
                    ch_reg_d = avs_writedata[adc_ctrl_pkg::IS_CH_LSB +: adc_ctrl_pkg::CH_W];
                end
                default: ;
            endcase
        end

        if (acc_rd && avs_address == adc_ctrl_pkg::RES_LO_OFF) begin
            lock_d = 1'b1;
        end
        if (acc_rd && avs_address == adc_ctrl_pkg::RES_HI_OFF) begin
            lock_d = 1'b0;
        end

        // new selection is applied only between conversions
        if (enable_q && !core_busy && !launch) begin
            ch_act_d = ch_reg_q;
        end

        // edges while converting are dropped; a level held high gives none
        if (enable_q && auto_q && trig_edge && !start_q) begin
            start_d = 1'b1;
            pcnt_d  = '0;
        end

        if (launch) begin
            first_d = 1'b0;
        end

        if (core_res.done) begin
            event_d     = 1'b1;
            done_flag_d = 1'b1;
            if (!lock_q) begin
                res_d = core_res.value;
            end
            if (!(auto_q && trig_sel_q == adc_ctrl_pkg::TRIG_FREERUN)) begin
                start_d = 1'b0;
            end
            // free running: start stays high and the next tick relaunches
        end

        if (!enable_q) begin
            start_d = 1'b0;
            first_d = 1'b1;
            pcnt_d  = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q       <= 1'b0;
            rdata_q     <= '0;
            enable_q    <= 1'b0;
            start_q     <= 1'b0;
            auto_q      <= 1'b0;
            done_flag_q <= 1'b0;
            presc_sel_q <= adc_ctrl_pkg::PRESC_RST;
            trig_sel_q  <= adc_ctrl_pkg::TRIG_FREERUN;
            left_q      <= 1'b0;
            ch_reg_q    <= adc_ctrl_pkg::CH_RST;
            ch_act_q    <= adc_ctrl_pkg::CH_RST;
            res_q       <= '0;
            lock_q      <= 1'b0;
            first_q     <= 1'b1;
            trig_prev_q <= 1'b0;
            pcnt_q      <= '0;
            event_q     <= 1'b0;
        end else begin
            ack_q       <= ack_d;
            rdata_q     <= rdata_d;
            enable_q    <= enable_d;
            start_q     <= start_d;
            auto_q      <= auto_d;
            done_flag_q <= done_flag_d;
            presc_sel_q <= presc_sel_d;
            trig_sel_q  <= trig_sel_d;
            left_q      <= left_d;
            ch_reg_q    <= ch_reg_d;
            ch_act_q    <= ch_act_d;
            res_q       <= res_d;
            lock_q      <= lock_d;
            first_q     <= first_d;
            trig_prev_q <= trig_prev_d;
            pcnt_q      <= pcnt_d;
            event_q     <= event_d;
        end
    end

    adc_sample_core u_core (
        .clk    (clk),
        .rst_n  (rst_n_q),
        .tick   (tick),
        .start  (launch),
        .first  (first_q),
        .abort  (!enable_q),
        .sample (sample_sel),
        .result (core_res),
        .busy   (core_busy)
    );

    assign avs_readdata    = rdata_q;
    assign channel_select  = ch_act_q;
    assign converter_on    = enable_q;
    assign conv_done_event = event_q;

endmodule

// [pkg/adc_ctrl_pkg.sv]
// constants, types and register layout for the converter control block
// Behaviour
// - four channels; selection idle while converter disabled
// - 10-bit result, right or left justified
// - low byte read blocks result updates
// - high byte read releases the update block
// - completion event raised even when result lost
// - start bit begins conversion, cleared at end
// - channel change waits until conversion ends
// - auto trigger enable with selectable source
// - trigger rising edge resets prescaler, starts conversion
// - trigger still high needs fresh rising edge
// - trigger edges ignored during a conversion
// - own completion flag source gives back-to-back conversions
// - start bit works and reads high under auto trigger
// - conversion 13 clocks, first after enable 25
// - completion writes result, sets flag, clears start
// - free running restarts immediately, start stays high
package adc_ctrl_pkg;

    localparam int unsigned ADDR_W   = 5;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned RES_W    = 10;
    localparam int unsigned CH_W     = 2;
    localparam int unsigned NUM_CH   = 4;
    localparam int unsigned TS_W     = 3;
    localparam int unsigned NUM_TRIG = 8;
    localparam int unsigned PRESC_W  = 3;
    localparam int unsigned PCNT_W   = 7;
    localparam int unsigned CNT_W    = 5;

    // word-aligned register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_A_OFF = 5'h00;
    localparam logic [ADDR_W-1:0] CTRL_B_OFF = 5'h04;
    localparam logic [ADDR_W-1:0] INSEL_OFF  = 5'h08;
    localparam logic [ADDR_W-1:0] RES_LO_OFF = 5'h0C;
    localparam logic [ADDR_W-1:0] RES_HI_OFF = 5'h10;

    // converter_control_a fields
    localparam int unsigned CA_ENABLE_BIT = 7;
    localparam int unsigned CA_START_BIT  = 6;
    localparam int unsigned CA_AUTO_BIT   = 5;
    localparam int unsigned CA_DONE_BIT   = 4;
    localparam int unsigned CA_PRESC_LSB  = 0;
    // converter_control_b field
    localparam int unsigned CB_TS_LSB     = 0;
    // input_select_register fields
    localparam int unsigned IS_LEFT_BIT   = 5;
    localparam int unsigned IS_CH_LSB     = 0;

    localparam logic [TS_W-1:0]    TRIG_FREERUN = 3'h0;
    localparam logic [PRESC_W-1:0] PRESC_RST    = 3'h0;
    localparam logic [CH_W-1:0]    CH_RST       = 2'h0;

    localparam logic [CNT_W-1:0] NORMAL_CYCLES = 5'h0D;
    localparam logic [CNT_W-1:0] FIRST_CYCLES  = 5'h19;

    typedef struct packed {
        logic             done;
        logic [RES_W-1:0] value;
    } conv_result_t;

    typedef enum logic [0:0] {
        CORE_IDLE = 1'b0,
        CORE_CONV = 1'b1
    } core_state_t;

endpackage

// [hdl/adc_sample_core.sv]
// sampling core stand-in: counts converter clocks and returns the held sample
module adc_sample_core (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              tick,
    input  wire logic                              start,
    input  wire logic                              first,
    input  wire logic                              abort,
    input  wire logic [adc_ctrl_pkg::RES_W-1:0]    sample,
    output adc_ctrl_pkg::conv_result_t             result,
    output logic                                   busy
);

    adc_ctrl_pkg::core_state_t             state_q, state_d;
    logic [adc_ctrl_pkg::CNT_W-1:0]        cnt_q, cnt_d;
    logic [adc_ctrl_pkg::CNT_W-1:0]        len_q, len_d;
    logic [adc_ctrl_pkg::RES_W-1:0]        hold_q, hold_d;
    adc_ctrl_pkg::conv_result_t            res_q, res_d;

    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        len_d      = len_q;
        hold_d     = hold_q;
        res_d      = res_q;
        res_d.done = 1'b0;
        case (state_q)
            adc_ctrl_pkg::CORE_IDLE: begin
                if (start && !abort) begin
                    state_d = adc_ctrl_pkg::CORE_CONV;
                    cnt_d   = '0;
                    // first conversion after enable needs the longer warm-up
                    len_d   = first ? adc_ctrl_pkg::FIRST_CYCLES
                                    : adc_ctrl_pkg::NORMAL_CYCLES;
                    hold_d  = sample;
                end
            end
            adc_ctrl_pkg::CORE_CONV: begin
                if (abort) begin
                    state_d = adc_ctrl_pkg::CORE_IDLE;
                end else if (tick) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_d == len_q) begin
                        state_d     = adc_ctrl_pkg::CORE_IDLE;
                        res_d.done  = 1'b1;
                        res_d.value = hold_q;
                    end
                end
            end
            default: state_d = adc_ctrl_pkg::CORE_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= adc_ctrl_pkg::CORE_IDLE;
            cnt_q   <= '0;
            len_q   <= adc_ctrl_pkg::NORMAL_CYCLES;
            hold_q  <= '0;
            res_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            len_q   <= len_d;
            hold_q  <= hold_d;
            res_q   <= res_d;
        end
    end

    assign result = res_q;
    assign busy   = (state_q == adc_ctrl_pkg::CORE_CONV);

endmodule

// [dv/adc_ctrl_assertions.sv]
// port-level checker for the converter control block
module adc_ctrl_checker (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [7:1]  trig_src,
    input wire logic [39:0] channel_sample,
    input wire logic [1:0]  channel_select,
    input wire logic        converter_on,
    input wire logic        conv_done_event
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request not held off in its first cycle");
    wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait cycle");
    read_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest
        && avs_address > adc_ctrl_pkg::RES_HI_OFF |-> avs_readdata == '0)
        else $error("unmapped read not zero");
    high_upper_a: assert property (avs_read && !avs_waitrequest && avs_address == adc_ctrl_pkg::RES_HI_OFF |-> avs_readdata[31:8] == '0)
        else $error("result byte has upper bits set");
    done_pulse_a: assert property (conv_done_event |=> !conv_done_event [*8])
        else $error("completion events too close");
    chan_gate_a: assert property ($changed(channel_select) |-> $past(converter_on))
        else $error("channel applied while converter off");
    chan_lock_a: assert property (conv_done_event |-> $past(channel_select, 3) == $past(channel_select, 9))
        else $error("channel changed inside a conversion");
    // a completion that lands on the disabling edge still reports one cycle later
    off_quiet_a: assert property (!converter_on && !$past(converter_on)
        && !$past(converter_on, 2) |-> !conv_done_event)
        else $error("completion while converter off");
    cover property (conv_done_event);
    cover property ($rose(|trig_src));
    cover property (avs_read && !avs_waitrequest && avs_address == adc_ctrl_pkg::RES_LO_OFF);
endmodule

bind adc_conv_ctrl adc_ctrl_checker i_chk (.clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .trig_src, .channel_sample,
    .channel_select, .converter_on, .conv_done_event);

// [dv/trig_flag_model.sv]
// on-chip interrupt flags feeding the trigger inputs
module trig_flag_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:1] set_ev,
    input  wire logic [7:1] clr_ev,
    output logic      [7:1] flags
);
    timeunit 1ns;
    timeprecision 1ps;
    // a flag stays set whatever the mask until the host clears it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) flags <= '0;
        else flags <= (flags & ~clr_ev) | set_ev;
    end
endmodule

// [dv/test_sar_adc_conversion_control.sv]
// self-checking bench for the converter control block
module test_sar_adc_conversion_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] EN = 32'h0000_0080, ST = 32'h0000_0040, AU = 32'h0000_0020;
    localparam logic [31:0] DN = 32'h0000_0010;
    logic clk, nrst, avs_read, avs_write, avs_waitrequest, converter_on, conv_done_event;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:1]  trig_src, set_ev, clr_ev, kb, jb;
    logic [39:0] channel_sample, s;
    logic [1:0]  channel_select;
    logic [9:0]  v;
    logic        lft;
    int n_mismatch, checks, cyc, t0, seed, i, k;
    adc_conv_ctrl i_dut (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .trig_src, .channel_sample, .channel_select,
        .converter_on, .conv_done_event);
    trig_flag_model i_trig (.clk, .nrst, .set_ev, .clr_ev, .flags(trig_src));
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    function automatic logic [31:0] expect_byte(logic [9:0] x, logic left, logic hi);
        logic [15:0] r;
        r = left ? {x, 6'h00} : {6'h00, x};
        return hi ? {24'h00_0000, r[15:8]} : {24'h00_0000, r[7:0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one Avalon transfer; the request stands until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a; avs_write <= w; avs_read <= !w; avs_writedata <= d;
        do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 64);
        q = avs_readdata;
        avs_read <= 0; avs_write <= 0;
        if (n >= 64) chk("bus answer", 0, 1);
    endtask
    task automatic wdone(input int lim);
        int n;
        n = 0;
        do begin @(negedge clk); n++; end while (conv_done_event !== 1'b1 && n < lim);
    endtask
    task automatic pulse(input logic [7:1] st, input logic [7:1] cl);
        @(posedge clk);
        set_ev <= st; clr_ev <= cl;
        @(posedge clk);
        set_ev <= '0; clr_ev <= '0;
    endtask
    task automatic conv(input logic [1:0] ch, input logic left, input int lo, input int hi,
                        input logic sw);
        s = {$random(seed), $random(seed)};
        channel_sample <= s;
        v = s[ch*10 +: 10];
        lft = left;
        bus(1, adc_ctrl_pkg::INSEL_OFF, {26'h000_0000, left, 3'h0, ch});
        // clearing the flag here proves the later flag read comes from this conversion
        bus(1, adc_ctrl_pkg::CTRL_A_OFF, EN | ST | DN);
        t0 = cyc;
        bus(0, adc_ctrl_pkg::CTRL_A_OFF, 0);
        chk("start bit busy", q[6], 1);
        if (sw) begin
            bus(1, adc_ctrl_pkg::INSEL_OFF, {30'h0000_0000, ch ^ 2'h3});
            repeat (2) @(posedge clk);
            chk("channel held", channel_select, ch);
        end
        wdone(200);
        chk("conversion time", (cyc - t0 >= lo) && (cyc - t0 <= hi), 1);
        bus(0, adc_ctrl_pkg::CTRL_A_OFF, 0);
        chk("start and done", {q[6], q[4]}, 2'h1);
        bus(0, adc_ctrl_pkg::RES_LO_OFF, 0);
        chk("result low", q, expect_byte(v, left, 0));
        bus(0, adc_ctrl_pkg::RES_HI_OFF, 0);
        chk("result high", q, expect_byte(v, left, 1));
        chk("channel applied", channel_select, sw ? ch ^ 2'h3 : ch);
    endtask
    task automatic summarize;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8000) @(posedge clk);
        n_mismatch++;
        summarize;
    end
    initial begin
        seed = 32'hbd4a_29d2;
        nrst = 0; avs_read = 0; avs_write = 0; avs_address = '0; avs_writedata = '0;
        set_ev = '0; clr_ev = '0; channel_sample = '0; cyc = 0;
        repeat (6) @(posedge clk);
        nrst <= 1;
        repeat (3) @(posedge clk);
        bus(0, adc_ctrl_pkg::CTRL_A_OFF, 0);
        chk("control reset", q, 0);
        bus(0, 5'h14, 0);
        chk("unmapped read", q, 0);
        bus(1, adc_ctrl_pkg::INSEL_OFF, 32'h0000_0003);
        repeat (2) @(posedge clk);
        chk("channel while off", channel_select, 0);
        bus(1, adc_ctrl_pkg::CTRL_A_OFF, EN);
        repeat (2) @(posedge clk);
        chk("converter on", converter_on, 1);
        chk("channel once on", channel_select, 3);
        for (i = 0; i < 5; i++) conv(i[1:0], i[0], i == 0 ? 52 : 28, i == 0 ? 55 : 31, i == 2);
        // inverted samples guarantee the dropped result differs from the held one
        channel_sample <= ~channel_sample;
        bus(1, adc_ctrl_pkg::CTRL_A_OFF, EN | ST);
        bus(0, adc_ctrl_pkg::RES_LO_OFF, 0);
        chk("locked low", q, expect_byte(v, lft, 0));
        wdone(200);
        chk("event while locked", conv_done_event, 1);
        bus(0, adc_ctrl_pkg::RES_HI_OFF, 0);
        chk("locked high", q, expect_byte(v, lft, 1));
        conv(2'h1, 1'b0, 28, 31, 1'b0);
        k = 1 + {$random(seed)} % 7;
        kb = 7'h01 << (k - 1);
        jb = 7'h01 << (k % 7);
        bus(1, adc_ctrl_pkg::CTRL_B_OFF, k);
        bus(1, adc_ctrl_pkg::CTRL_A_OFF, EN | AU);
        pulse(kb, '0);
        pulse('0, kb);
        pulse(kb, '0);
        wdone(100);
        chk("triggered done", conv_done_event, 1);
        pulse(jb, '0);
        wdone(80);
        chk("no retrigger", conv_done_event, 0);
        pulse('0, kb);
        pulse(kb, '0);
        bus(0, adc_ctrl_pkg::CTRL_A_OFF, 0);
        chk("start under auto", q[6], 1);
        wdone(100);
        chk("fresh edge done", conv_done_event, 1);
        // trigger level still high: only the start bit can begin this one
        bus(1, adc_ctrl_pkg::CTRL_A_OFF, EN | AU | ST);
        wdone(100);
        chk("start under auto done", conv_done_event, 1);
        bus(1, adc_ctrl_pkg::CTRL_B_OFF, 0);
        bus(1, adc_ctrl_pkg::CTRL_A_OFF, EN | AU | ST);
        for (i = 0; i < 3; i++) begin
            wdone(100);
            chk("free run done", conv_done_event, 1);
            bus(0, adc_ctrl_pkg::CTRL_A_OFF, 0);
            chk("free run start", {q[6], q[4]}, 2'h3);
        end
        bus(1, adc_ctrl_pkg::CTRL_A_OFF, 0);
        wdone(80);
        chk("stopped", conv_done_event, 0);
        chk("converter off", converter_on, 0);
        summarize;
    end
endmodule
